// file: logic/hd_pkg.sv
`default_nettype none
package hd_pkg;

  // Word and code widths of the protected word.
  localparam int HD_DATA_W = 32;
  localparam int HD_CHK_W = 7;
  localparam int HD_SYN_W = 8;

  // Data bits feeding each check bit, check bit 6 in the top slot.
  localparam logic [6:0][31:0] HD_CB_MASK = {
    32'hf8cf8886,
    32'h86b46f61,
    32'h6f2a161d,
    32'hc8c8f791,
    32'h844dc57e,
    32'h5313b3d8,
    32'hf1388f32
  };

  // Check bits 4 and 2 are stored inverted.
  localparam logic [6:0] HD_CB_INV = 7'h14;

  // Syndrome of a clean word, and of a word whose stored parity alone is wrong.
  localparam logic [7:0] HD_SYN_CLEAN = 8'h80;
  localparam logic [7:0] HD_SYN_PAR = 8'h00;

  // Reset values of the data, check bit and syndrome registers.
  localparam logic [31:0] HD_DATA_RST = 32'h00000000;
  localparam logic [6:0] HD_CHK_RST = 7'h00;
  localparam logic [7:0] HD_SYN_RST = 8'h00;

  // Check bits of a data word, inversions included.
  function automatic logic [6:0] hd_check_f(input logic [31:0] data);
    logic [6:0] cb;
    cb = '0;
    for (int j = 0; j < HD_CHK_W; j++) begin
      cb[j] = (^(data & HD_CB_MASK[j])) ^ HD_CB_INV[j];
    end
    return cb;
  endfunction : hd_check_f

  // Syndrome column that a flipped data bit produces.
  function automatic logic [6:0] hd_col_f(input int idx);
    logic [6:0] col;
    col = '0;
    for (int j = 0; j < HD_CHK_W; j++) begin
      col[j] = HD_CB_MASK[j][idx];
    end
    return col;
  endfunction : hd_col_f

endpackage : hd_pkg
`default_nettype wire

// file: logic/hd_cw_if.sv
`timescale 1ns/1ps
`default_nettype none
// Data word and its code bits passed to a check bit generator.
interface hd_cw_if;
  logic [31:0] data;
  logic [6:0] check;
  logic parity;
  modport gen (input data, output check, output parity);
  modport user (output data, input check, input parity);
endinterface : hd_cw_if
`default_nettype wire

// file: logic/hd_check_gen.sv
`timescale 1ns/1ps
`default_nettype none
module hd_check_gen (
  hd_cw_if.gen cw
);
  import hd_pkg::*;

  // Seven check bits and the odd parity bit of the word.
  assign cw.check = hd_check_f(cw.data);
  assign cw.parity = ~(^cw.data);

endmodule : hd_check_gen
`default_nettype wire

// file: logic/hd_syn_dec.sv
`timescale 1ns/1ps
`default_nettype none
module hd_syn_dec (
  input wire logic [hd_pkg::HD_SYN_W-1:0] syn_i,
  output logic [hd_pkg::HD_DATA_W-1:0] flip_o,
  output logic correctable_o,
  output logic uncorrectable_o
);
  import hd_pkg::*;

  logic data_hit;
  logic chk_hit;
  logic par_hit;

  // A data bit error leaves the top bit clear and shows the bit's column.
  always_comb begin
    flip_o = '0;
    data_hit = 1'b0;
    for (int i = 0; i < HD_DATA_W; i++) begin
      if (syn_i == {1'b0, hd_col_f(i)}) begin
        flip_o[i] = 1'b1;
        data_hit = 1'b1;
      end
    end
  end

  // A check bit error keeps the top bit set and flips one lower bit.
  assign chk_hit = syn_i[7] && $onehot(syn_i[6:0]);
  assign par_hit = (syn_i == HD_SYN_PAR);

  // Anything else than a known pattern or a clean word cannot be repaired.
  assign correctable_o = data_hit || chk_hit || par_hit;
  assign uncorrectable_o = !correctable_o && (syn_i != HD_SYN_CLEAN);

endmodule : hd_syn_dec
`default_nettype wire

// file: logic/hd_edac.sv
`timescale 1ns/1ps
`default_nettype none
module hd_edac #(
  parameter int DATA_W = 32
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic edac_en_i,
  input wire logic test_check_sel_i,
  input wire logic [hd_pkg::HD_CHK_W-1:0] test_check_bits_i,
  input wire logic wr_valid_i,
  input wire logic [hd_pkg::HD_DATA_W-1:0] wr_data_i,
  output logic mem_wr_valid_o,
  output logic [hd_pkg::HD_DATA_W-1:0] mem_wr_data_o,
  output logic [hd_pkg::HD_CHK_W-1:0] mem_check_bits_o,
  output logic mem_data_parity_line_o,
  input wire logic rd_valid_i,
  input wire logic [hd_pkg::HD_DATA_W-1:0] mem_rd_data_i,
  input wire logic [hd_pkg::HD_CHK_W-1:0] mem_rd_check_bits_i,
  input wire logic mem_rd_data_parity_line_i,
  output logic rd_valid_o,
  output logic [hd_pkg::HD_DATA_W-1:0] rd_data_o,
  output logic rd_uncorrectable_o,
  output logic [hd_pkg::HD_SYN_W-1:0] error_pattern_bits_o,
  output logic correctable_irq_o,
  output logic memory_exception_out_n_o
);
  import hd_pkg::*;

  // The correction tables are built for one word width only.
  if (DATA_W != HD_DATA_W) begin : g_bad_width
    $error("hd_edac supports a 32-bit data word only");
  end

  hd_cw_if wr_cw ();
  hd_cw_if rd_cw ();

  logic [HD_SYN_W-1:0] syn;
  logic [HD_DATA_W-1:0] flip;
  logic corr;
  logic uncorr;
  logic chk_on;

  logic mem_wr_valid_q;
  logic [HD_DATA_W-1:0] mem_wr_data_q;
  logic [HD_CHK_W-1:0] mem_check_bits_q;
  logic mem_parity_q;
  logic [HD_CHK_W-1:0] wr_check_d;

  logic rd_valid_q;
  logic [HD_DATA_W-1:0] rd_data_q;
  logic rd_uncorr_q;
  logic [HD_SYN_W-1:0] syn_q;
  logic irq_q;
  logic memory_exception_out_n_q;
  logic [HD_DATA_W-1:0] raw_q;
  logic [HD_DATA_W-1:0] wr_word;

  // Write side generator sees the word coming from the core.
  assign wr_cw.data = wr_data_i;
  hd_check_gen u_wr_gen (
    .cw(wr_cw.gen)
  );

  // Read side generator recomputes the code from the word read back.
  assign rd_cw.data = mem_rd_data_i;
  hd_check_gen u_rd_gen (
    .cw(rd_cw.gen)
  );

  // Syndrome from recomputed and stored code bits.
  assign syn[6:0] = rd_cw.check ^ mem_rd_check_bits_i;
  assign syn[7] = (^(rd_cw.check ^ HD_CB_INV)) ^ mem_rd_data_parity_line_i;

  hd_syn_dec u_dec (
    .syn_i(syn),
    .flip_o(flip),
    .correctable_o(corr),
    .uncorrectable_o(uncorr)
  );

  // Checking only happens on a read with correction switched on.
  assign chk_on = rd_valid_i && edac_en_i;

  // Test value replaces the generated check bits when selected.
  assign wr_check_d = test_check_sel_i ? test_check_bits_i : wr_cw.check;

  // Write path: only core writes reach the memory, never a repaired read.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_wr_valid_q <= 1'b0;
      mem_wr_data_q <= HD_DATA_RST;
      mem_check_bits_q <= HD_CHK_RST;
      mem_parity_q <= 1'b0;
    end else begin
      mem_wr_valid_q <= wr_valid_i;
      if (wr_valid_i) begin
        mem_wr_data_q <= wr_data_i;
        mem_check_bits_q <= wr_check_d;
        mem_parity_q <= wr_cw.parity;
      end
    end
  end

  // Read data path: repaired word, or the raw word when checking is off.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= HD_DATA_RST;
      raw_q <= HD_DATA_RST;
    end else begin
      rd_valid_q <= rd_valid_i;
      if (rd_valid_i) begin
        raw_q <= mem_rd_data_i;
        rd_data_q <= chk_on ? (mem_rd_data_i ^ flip) : mem_rd_data_i;
      end
    end
  end

  // Syndrome stays visible until the next checked read.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      syn_q <= HD_SYN_RST;
    end else if (chk_on) begin
      syn_q <= syn;
    end
  end

  // Error indications are single-cycle pulses aligned with rd_valid_o.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_uncorr_q <= 1'b0;
      irq_q <= 1'b0;
      memory_exception_out_n_q <= 1'b1;
    end else begin
      rd_uncorr_q <= chk_on && uncorr;
      irq_q <= chk_on && corr;
      memory_exception_out_n_q <= !(chk_on && uncorr);
    end
  end

  // Every output comes straight from its register.
  assign mem_wr_valid_o = mem_wr_valid_q;
  assign mem_wr_data_o = mem_wr_data_q;
  assign mem_check_bits_o = mem_check_bits_q;
  assign mem_data_parity_line_o = mem_parity_q;
  assign rd_valid_o = rd_valid_q;
  assign rd_data_o = rd_data_q;
  assign rd_uncorrectable_o = rd_uncorr_q;
  assign error_pattern_bits_o = syn_q;
  assign correctable_irq_o = irq_q;
  assign memory_exception_out_n_o = memory_exception_out_n_q;

  // All checks below run on the system clock and pause during reset.
  default clocking cb_main @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  // Stored write word, as the per-bit check bit assertions see it.
  assign wr_word = mem_wr_data_q;

  // Generated check bits land on the memory side one cycle after the write.
  AST_WR_GEN: assert property (
    wr_valid_i && !test_check_sel_i
    |=> mem_check_bits_o == hd_check_f($past(wr_data_i)) && mem_wr_valid_o
  ) else $error("written check bits do not match the data word");

  // Check bit 0 follows its own list of data bits.
  AST_CB0: assert property (
    wr_valid_i && !test_check_sel_i |=> mem_check_bits_o[0] == ^{
      wr_word[31], wr_word[30], wr_word[29], wr_word[28], wr_word[24], wr_word[21],
      wr_word[20], wr_word[19], wr_word[15], wr_word[11], wr_word[10], wr_word[9],
      wr_word[8], wr_word[5], wr_word[4], wr_word[1]}
  ) else $error("check bit 0 does not follow its data bits");

  // Check bit 1 follows its own list of data bits.
  AST_CB1: assert property (
    wr_valid_i && !test_check_sel_i |=> mem_check_bits_o[1] == ^{
      wr_word[30], wr_word[28], wr_word[25], wr_word[24], wr_word[20], wr_word[17],
      wr_word[16], wr_word[15], wr_word[13], wr_word[12], wr_word[9], wr_word[8],
      wr_word[7], wr_word[6], wr_word[4], wr_word[3]}
  ) else $error("check bit 1 does not follow its data bits");

  // Check bit 2 is the inverted sum of its own list of data bits.
  AST_CB2: assert property (
    wr_valid_i && !test_check_sel_i |=> mem_check_bits_o[2] == ~^{
      wr_word[31], wr_word[26], wr_word[22], wr_word[19], wr_word[18], wr_word[16],
      wr_word[15], wr_word[14], wr_word[10], wr_word[8], wr_word[6], wr_word[5],
      wr_word[4], wr_word[3], wr_word[2], wr_word[1]}
  ) else $error("check bit 2 does not follow its data bits");

  // Check bit 3 follows its own list of data bits.
  AST_CB3: assert property (
    wr_valid_i && !test_check_sel_i |=> mem_check_bits_o[3] == ^{
      wr_word[31], wr_word[30], wr_word[27], wr_word[23], wr_word[22], wr_word[19],
      wr_word[15], wr_word[14], wr_word[13], wr_word[12], wr_word[10], wr_word[9],
      wr_word[8], wr_word[7], wr_word[4], wr_word[0]}
  ) else $error("check bit 3 does not follow its data bits");

  // Check bit 4 is the inverted sum of its own list of data bits.
  AST_CB4: assert property (
    wr_valid_i && !test_check_sel_i |=> mem_check_bits_o[4] == ~^{
      wr_word[30], wr_word[29], wr_word[27], wr_word[26], wr_word[25], wr_word[24],
      wr_word[21], wr_word[19], wr_word[17], wr_word[12], wr_word[10], wr_word[9],
      wr_word[4], wr_word[3], wr_word[2], wr_word[0]}
  ) else $error("check bit 4 does not follow its data bits");

  // Check bit 5 follows its own list of data bits.
  AST_CB5: assert property (
    wr_valid_i && !test_check_sel_i |=> mem_check_bits_o[5] == ^{
      wr_word[31], wr_word[26], wr_word[25], wr_word[23], wr_word[21], wr_word[20],
      wr_word[18], wr_word[14], wr_word[13], wr_word[11], wr_word[10], wr_word[9],
      wr_word[8], wr_word[6], wr_word[5], wr_word[0]}
  ) else $error("check bit 5 does not follow its data bits");

  // Check bit 6 follows its own list of data bits.
  AST_CB6: assert property (
    wr_valid_i && !test_check_sel_i |=> mem_check_bits_o[6] == ^{
      wr_word[31], wr_word[30], wr_word[29], wr_word[28], wr_word[27], wr_word[23],
      wr_word[22], wr_word[19], wr_word[18], wr_word[17], wr_word[16], wr_word[15],
      wr_word[11], wr_word[7], wr_word[2], wr_word[1]}
  ) else $error("check bit 6 does not follow its data bits");

  // Selected test value overrides the generated check bits.
  AST_WR_TEST: assert property (
    wr_valid_i && test_check_sel_i
    |=> mem_check_bits_o == $past(test_check_bits_i)
  ) else $error("test check bits not used on a test write");

  // Parity written is odd over the whole data word.
  AST_WR_PAR: assert property (
    wr_valid_i |=> (^{mem_data_parity_line_o, mem_wr_data_o}) == 1'b1
  ) else $error("written parity is not odd");

  // A memory write only ever follows a core write.
  AST_NO_WRITEBACK: assert property (
    mem_wr_valid_o |-> $past(wr_valid_i)
  ) else $error("memory write issued without a core write");

  // Syndrome recomputed from the stored word, top bit included.
  AST_SYNDROME: assert property (
    chk_on |=> error_pattern_bits_o == {
      ^({$past(mem_rd_check_bits_i), $past(mem_rd_data_parity_line_i)}
        ^ {hd_check_f($past(mem_rd_data_i)), 1'b0}
        ^ {hd_check_f($past(mem_rd_data_i)) ^ HD_CB_INV, 1'b0})
        ^ (^(hd_check_f($past(mem_rd_data_i)) ^ HD_CB_INV))
        ^ (^$past(mem_rd_check_bits_i)),
      hd_check_f($past(mem_rd_data_i)) ^ $past(mem_rd_check_bits_i)}
  ) else $error("syndrome does not follow the read word");

  // A corrected data error changes exactly one bit of the read word.
  AST_ONE_FLIP: assert property (
    rd_valid_o && correctable_irq_o && !error_pattern_bits_o[7]
    && error_pattern_bits_o != HD_SYN_PAR
    |-> $countones(rd_data_o ^ raw_q) == 1
  ) else $error("single bit error not repaired by one flip");

  // Check bit and parity errors leave the data word untouched.
  AST_CHK_ONLY: assert property (
    rd_valid_o && (error_pattern_bits_o[7] || error_pattern_bits_o == HD_SYN_PAR)
    && !rd_uncorrectable_o |-> rd_data_o == raw_q
  ) else $error("data changed on a check bit syndrome");

  // A clean word raises nothing and passes unchanged.
  AST_CLEAN: assert property (
    chk_on && syn == HD_SYN_CLEAN
    |=> !rd_uncorrectable_o && !correctable_irq_o && rd_data_o == raw_q
  ) else $error("clean syndrome raised an error");

  // Uncorrectable reads pull the exception low in step with the flag.
  AST_MEMORY_EXCEPTION_OUT: assert property (
    (rd_uncorrectable_o == !memory_exception_out_n_o)
    and (rd_uncorrectable_o |-> rd_valid_o && !correctable_irq_o)
  ) else $error("exception and uncorrectable flag disagree");

  // A nonzero even weight syndrome with the top bit clear is always uncorrectable.
  AST_DOUBLE: assert property (
    chk_on && !syn[7] && syn[6:0] != 7'h00 && ($countones(syn[6:0]) % 2) == 0
    |=> rd_uncorrectable_o
  ) else $error("even weight syndrome not flagged");

  // A word stuck at all ones or all zeros with matching code bits is refused.
  AST_STUCK: assert property (
    chk_on && (mem_rd_data_i == '0 || mem_rd_data_i == '1)
    && mem_rd_check_bits_i == {HD_CHK_W{mem_rd_data_i[0]}}
    && mem_rd_data_parity_line_i == mem_rd_data_i[0]
    |=> rd_uncorrectable_o ##1 memory_exception_out_n_o
  ) else $error("stuck word not flagged uncorrectable");

  // Corrected errors request the interrupt for exactly one cycle.
  AST_IRQ: assert property (
    chk_on && corr |=> correctable_irq_o ##1 (correctable_irq_o == $past(chk_on && corr))
  ) else $error("correctable interrupt not raised");

  // With correction off the word passes raw and nothing is flagged.
  AST_DISABLED: assert property (
    rd_valid_i && !edac_en_i
    |=> rd_data_o == $past(mem_rd_data_i) && !correctable_irq_o
    && memory_exception_out_n_o && $stable(error_pattern_bits_o)
  ) else $error("read checked while correction is off");

  // A stored parity fault alone leaves the data as read and raises no exception.
  AST_PAR_ONLY: assert property (
    chk_on && syn == HD_SYN_PAR
    |=> correctable_irq_o && memory_exception_out_n_o && rd_data_o == raw_q
  ) else $error("parity only syndrome not handled as correctable");

  // With matching check bits the top syndrome bit says whether the parity agrees.
  AST_SYN_TOP: assert property (
    chk_on && syn[6:0] == 7'h00 |-> syn[7] == (mem_rd_data_parity_line_i == rd_cw.parity)
  ) else $error("top syndrome bit disagrees with the read parity");

  // Main scenarios worth seeing.
  COV_CORR_DATA: cover property (chk_on && corr && !syn[7] ##1 rd_valid_o);
  COV_CORR_CHK: cover property (chk_on && corr && syn[7]);
  COV_UNCORR: cover property (chk_on && uncorr ##1 !memory_exception_out_n_o);
  COV_TEST_WR: cover property (wr_valid_i && test_check_sel_i);
  COV_PAR_ONLY: cover property (chk_on && syn == HD_SYN_PAR);

endmodule : hd_edac
`default_nettype wire

// file: verification/hd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// External memory holding one 40-bit word, with read faults commanded by the bench.
module hd_mem_model (
  input wire logic core_clk_i,
  input wire logic mem_wr_valid_i,
  input wire logic [31:0] mem_wr_data_i,
  input wire logic [6:0] mem_check_bits_i,
  input wire logic mem_data_parity_line_i,
  input wire logic rd_req_i,
  input wire logic [39:0] rd_flip_i,
  output logic rd_valid_o,
  output logic [31:0] rd_data_o,
  output logic [6:0] rd_check_bits_o,
  output logic rd_data_parity_line_o
);
  logic [39:0] store_q = 40'h0;
  logic [39:0] word_q = 40'h0;
  logic valid_q = 1'b0;
  // Keep the whole word that the controller stores.
  always_ff @(posedge core_clk_i) begin
    if (mem_wr_valid_i) begin
      store_q <= {mem_data_parity_line_i, mem_check_bits_i, mem_wr_data_i};
    end
  end
  // Drive a read for one cycle; a released bus shows the inverse of its last value.
  always_ff @(posedge core_clk_i) begin
    valid_q <= rd_req_i;
    word_q <= rd_req_i ? (store_q ^ rd_flip_i) : ~word_q;
  end
  // Split the word onto the read lines.
  assign rd_valid_o = valid_q;
  assign {rd_data_parity_line_o, rd_check_bits_o, rd_data_o} = word_q;
endmodule : hd_mem_model
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hd_pkg::*;
  typedef struct packed {logic p; logic [6:0] c; logic [31:0] d;} hd_tb_wr_t;
  typedef struct packed {logic [31:0] d; logic [7:0] s; logic u; logic q;} hd_tb_rd_t;
  // Data bits feeding each check bit, check bit 0 first.
  localparam logic [31:0] MSK [7] = '{32'hf1388f32, 32'h5313b3d8, 32'h844dc57e,
    32'hc8c8f791, 32'h6f2a161d, 32'h86b46f61, 32'hf8cf8886};
  logic core_clk_i = 1'b0, nrst_i = 1'b0, edac_en_i = 1'b0, test_check_sel_i = 1'b0;
  logic wr_valid_i = 1'b0, rd_req = 1'b0;
  logic [6:0] test_check_bits_i = 7'h00;
  logic [31:0] wr_data_i = 32'h0;
  logic [39:0] rd_flip = 40'h0, st = 40'h0;
  logic mem_wr_valid_o, mem_data_parity_line_o, rd_valid_o, rd_uncorrectable_o;
  logic correctable_irq_o, memory_exception_out_n_o, rd_valid_i, mem_rd_data_parity_line_i;
  logic [31:0] mem_wr_data_o, rd_data_o, mem_rd_data_i;
  logic [6:0] mem_check_bits_o, mem_rd_check_bits_i;
  logic [7:0] error_pattern_bits_o, last_syn = 8'h00;
  int mismatches = 0, cmp_count = 0, a, b;
  integer seed = 32'h83c5e0fe;
  hd_tb_wr_t wq[$];
  hd_tb_rd_t rq[$];
  hd_edac DUT (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .edac_en_i(edac_en_i),
    .test_check_sel_i(test_check_sel_i), .test_check_bits_i(test_check_bits_i),
    .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i), .mem_wr_valid_o(mem_wr_valid_o),
    .mem_wr_data_o(mem_wr_data_o), .mem_check_bits_o(mem_check_bits_o),
    .mem_data_parity_line_o(mem_data_parity_line_o), .rd_valid_i(rd_valid_i),
    .mem_rd_data_i(mem_rd_data_i), .mem_rd_check_bits_i(mem_rd_check_bits_i),
    .mem_rd_data_parity_line_i(mem_rd_data_parity_line_i), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .rd_uncorrectable_o(rd_uncorrectable_o),
    .error_pattern_bits_o(error_pattern_bits_o), .correctable_irq_o(correctable_irq_o),
    .memory_exception_out_n_o(memory_exception_out_n_o));
  hd_mem_model mem (.core_clk_i(core_clk_i), .mem_wr_valid_i(mem_wr_valid_o),
    .mem_wr_data_i(mem_wr_data_o), .mem_check_bits_i(mem_check_bits_o),
    .mem_data_parity_line_i(mem_data_parity_line_o), .rd_req_i(rd_req), .rd_flip_i(rd_flip),
    .rd_valid_o(rd_valid_i), .rd_data_o(mem_rd_data_i), .rd_check_bits_o(mem_rd_check_bits_i),
    .rd_data_parity_line_o(mem_rd_data_parity_line_i));
  // Free-running system clock.
  always #5 core_clk_i = ~core_clk_i;
  // Check bits of a word, bits 2 and 4 inverted.
  function automatic logic [6:0] gen_f(input logic [31:0] d);
    logic [6:0] c;
    for (int j = 0; j < 7; j++) c[j] = (^(d & MSK[j])) ^ (j == 2 || j == 4);
    return c;
  endfunction : gen_f
  // Expected read result of a 40-bit word {parity, check, data}.
  function automatic hd_tb_rd_t exp_f(input logic [39:0] w, input logic en);
    logic [6:0] r, col;
    hd_tb_rd_t e;
    r = gen_f(w[31:0]);
    e.s = {(^(r ^ 7'h14)) ^ w[39], r ^ w[38:32]};
    e.d = w[31:0];
    e.u = (e.s != 8'h80);
    e.q = (e.s == 8'h00) || (e.s[7] && $countones(e.s[6:0]) == 1);
    for (int i = 0; i < 32; i++) begin
      for (int j = 0; j < 7; j++) col[j] = MSK[j][i];
      if (e.s == {1'b0, col}) begin
        e.d[i] = ~e.d[i];
        e.q = 1'b1;
      end
    end
    if (e.q) e.u = 1'b0;
    if (!en) e = '{d: w[31:0], s: last_syn, u: 1'b0, q: 1'b0};
    return e;
  endfunction : exp_f
  task chk(input string nm, input logic [39:0] ex, input logic [39:0] got);
    cmp_count++;
    if (got !== ex) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task cmp_wr(input hd_tb_wr_t e);
    chk("mem_wr_data", 40'(e.d), 40'(mem_wr_data_o));
    chk("mem_check_bits", 40'(e.c), 40'(mem_check_bits_o));
    chk("mem_parity", 40'(e.p), 40'(mem_data_parity_line_o));
  endtask : cmp_wr
  task cmp_rd(input hd_tb_rd_t e);
    chk("rd_data", 40'(e.d), 40'(rd_data_o));
    chk("syndrome", 40'(e.s), 40'(error_pattern_bits_o));
    chk("uncorrectable", 40'(e.u), 40'(rd_uncorrectable_o));
    chk("irq", 40'(e.q), 40'(correctable_irq_o));
    chk("exception_n", 40'(!e.u), 40'(memory_exception_out_n_o));
  endtask : cmp_rd
  task do_wr(input logic [31:0] d, input logic sel);
    hd_tb_wr_t e;
    logic [6:0] t;
    t = 7'($random(seed));
    e = '{p: ~^d, c: sel ? t : gen_f(d), d: d};
    wq.push_back(e);
    st = e;
    @(posedge core_clk_i);
    wr_valid_i <= 1'b1;
    wr_data_i <= d;
    test_check_sel_i <= sel;
    test_check_bits_i <= t;
    @(posedge core_clk_i);
    wr_valid_i <= 1'b0;
  endtask : do_wr
  task do_rd(input logic [39:0] f, input logic en);
    hd_tb_rd_t e;
    e = exp_f(st ^ f, en);
    if (en) last_syn = e.s;
    rq.push_back(e);
    @(posedge core_clk_i);
    rd_req <= 1'b1;
    rd_flip <= f;
    edac_en_i <= en;
    @(posedge core_clk_i);
    rd_req <= 1'b0;
    @(posedge core_clk_i);
  endtask : do_rd
  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // Each result takes the oldest note; a result with no note is itself a fault.
  always @(negedge core_clk_i) begin
    if (nrst_i && mem_wr_valid_o === 1'b1) begin
      if (wq.size() == 0) chk("mem_wr_valid", 40'h0, 40'h1);
      else cmp_wr(wq.pop_front());
    end
    if (nrst_i && rd_valid_o === 1'b1) begin
      if (rq.size() == 0) chk("rd_valid", 40'h0, 40'h1);
      else cmp_rd(rq.pop_front());
    end
  end
  // Main sequence of tests.
  initial begin
    repeat (5) @(posedge core_clk_i);
    chk("reset_exception_n", 40'h1, 40'(memory_exception_out_n_o));
    chk("reset_syndrome", 40'(HD_SYN_RST), 40'(error_pattern_bits_o));
    nrst_i <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      do_wr($random(seed), 1'b0);
      do_rd(40'h0, 1'b1);
      for (int i = 0; i < 40; i++) do_rd(40'h1 << i, 1'b1);
    end
    $display("test single_fault done");
    for (int k = 0; k < 24; k++) begin
      a = {$random(seed)} % 40;
      b = (a + 1 + {$random(seed)} % 39) % 40;
      do_rd((40'h1 << a) | (40'h1 << b), 1'b1);
    end
    $display("test double_fault done");
    for (int n = 0; n < 8; n++) begin
      do_rd(st & (40'hf << (4 * n)), 1'b1);
      do_rd(~st & (40'hf << (4 * n)), 1'b1);
    end
    do_rd(st, 1'b1);
    do_rd(~st, 1'b1);
    $display("test stuck_at done");
    for (int k = 0; k < 4; k++) begin
      do_wr($random(seed), 1'b1);
      do_rd(40'h0, 1'b1);
    end
    $display("test check_select done");
    do_rd(40'h1 << ({$random(seed)} % 40), 1'b0);
    do_rd(st, 1'b0);
    do_rd(40'h1, 1'b1);
    $display("test disabled done");
    repeat (4) @(posedge core_clk_i);
    chk("pending_notes", 40'h0, 40'(wq.size() + rq.size()));
    complete_run();
  end
  // Watchdog against a hang, far beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge core_clk_i);
    mismatches++;
    $display("watchdog expired");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
